// >>> otd_pkg.sv
// shared constants, types and register map of the operand transfer datapath
package otd_pkg;
    localparam int          WORD_W        = 25;
    localparam int          MAG_W         = 24;
    localparam int          SIGN_BIT      = 24;
    localparam int          ADDR_W        = 15;
    localparam int          NUM_AR        = 4;
    localparam int          NUM_XR        = 16;
    localparam int          DIGITS        = 6;
    // opcodes are printed as two hex digits
    localparam logic [5:0]  OP_STORE      = 6'h08;
    localparam logic [5:0]  OP_STORE_NEG  = 6'h09;
    localparam logic [5:0]  OP_LOAD       = 6'h0a;
    localparam logic [5:0]  OP_LOAD_NEG   = 6'h0b;
    localparam logic [5:0]  OP_LOAD_FIELD = 6'h0c;
    localparam logic [5:0]  OP_DEC_ADD    = 6'h10;
    localparam logic [3:0]  XS3_ZERO      = 4'h3;
    localparam logic [4:0]  BOUND_BIAS    = 5'h04;
    localparam logic [4:0]  BOUND_MAX     = 5'h1b;
    // register map, byte addresses
    localparam logic [7:0]  OFF_AR_BASE   = 8'h00;
    localparam logic [7:0]  OFF_CTRL      = 8'h10;
    localparam logic [7:0]  OFF_STAT      = 8'h14;
    localparam logic [7:0]  OFF_XR_BASE   = 8'h40;
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam int          STAT_ZERO_BIT = 0;
    localparam int          STAT_BUSY_BIT = 1;
    localparam int          STAT_CWERR_BIT = 2;

    typedef struct packed {
        logic             ia;
        logic [3:0]       xsel;
        logic [5:0]       op;
        logic [3:0]       bank;
        logic [9:0]       m;
    } otd_instr_s;

    typedef struct packed {
        logic             ia;
        logic [3:0]       xsel;
        logic [4:0]       left;
        logic [4:0]       right;
        logic [9:0]       m;
    } otd_field_control_word_s;

    typedef struct packed {
        logic             rd;
        logic             wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } otd_mem_req_s;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_CTRL  = 7'h02,
        ST_CWAN  = 7'h04,
        ST_OPRD  = 7'h08,
        ST_EXEC  = 7'h10,
        ST_STCLR = 7'h20,
        ST_STWR  = 7'h40
    } otd_state_e;
endpackage

// >>> otd_datapath.sv
// operand transfer and decimal add datapath with apb register access
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module otd_datapath
    import otd_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire otd_instr_s   instr_i,
    input  wire logic         instr_valid_i,
    output logic              instr_ready_o,
    output logic              done_o,
    output otd_mem_req_s      mem_req_o,
    input  wire logic [24:0]  mem_rdata_i,
    output logic              zero_result_flag_o,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr
);
    otd_state_e        st_r, st_nxt;
    logic [WORD_W-1:0] ar_r [NUM_AR];
    logic [ADDR_W-1:0] xr_r [NUM_XR];
    logic [5:0]        op_r;
    logic [3:0]        bank_r, pend_r;
    logic              field_control_word_r, en_r, cwerr_r, zero_flag_r;
    logic [ADDR_W-1:0] addr_r;
    logic [MAG_W-1:0]  mask_r;
    logic [31:0]       prdata_r;

    // decode of the incoming instruction
    wire op_is_ld   = instr_i.op == OP_LOAD || instr_i.op == OP_LOAD_NEG;
    wire op_is_st   = instr_i.op == OP_STORE || instr_i.op == OP_STORE_NEG;
    wire op_ours    = op_is_ld || op_is_st || instr_i.op == OP_LOAD_FIELD
                      || instr_i.op == OP_DEC_ADD;
    wire accept     = instr_valid_i && instr_ready_o;
    wire [ADDR_W-1:0] m_idx = {5'h00, instr_i.m} + xr_r[instr_i.xsel];
    wire cur_store  = op_r == OP_STORE || op_r == OP_STORE_NEG;

    // control word analysis
    otd_field_control_word_s cw;
    assign cw = mem_rdata_i;
    wire cw_field_control_word = cw.left != 5'h00;
    wire cw_bad  = cw_field_control_word && cw.ia;
    wire [ADDR_W-1:0] cw_addr = cw_field_control_word ? ({5'h00, cw.m} + xr_r[cw.xsel])
                                        : cw[ADDR_W-1:0];
    logic [MAG_W-1:0] cw_mask;
    genvar b;
    generate
        for (b = 0; b < MAG_W; b++) begin : g_mask
            // boundaries are excess-four coded bit positions
            assign cw_mask[b] = (5'(b) + BOUND_BIAS >= cw.right)
                                && (5'(b) + BOUND_BIAS <= cw.left);
        end
    endgenerate

    function automatic logic [1:0] low_idx(input logic [3:0] v);
        low_idx = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    endfunction

    // algebraic excess-three add, 6 digits plus sign
    function automatic logic [WORD_W-1:0] xs3_add(input logic [WORD_W-1:0] a,
                                                  input logic [WORD_W-1:0] c);
        logic [MAG_W-1:0] ba, bc, x, y, r;
        logic [4:0]       t;
        logic             cy, sg;
        ba = '0;
        bc = '0;
        r  = '0;
        for (int i = 0; i < DIGITS; i++) begin
            // pure binary zero digit counts as excess-three zero
            ba[4*i+:4] = (a[4*i+:4] == 4'h0) ? 4'h0 : a[4*i+:4] - XS3_ZERO;
            bc[4*i+:4] = (c[4*i+:4] == 4'h0) ? 4'h0 : c[4*i+:4] - XS3_ZERO;
        end
        cy = 1'b0;
        if (a[SIGN_BIT] == c[SIGN_BIT]) begin
            sg = a[SIGN_BIT];
            for (int i = 0; i < DIGITS; i++) begin
                t  = {1'b0, ba[4*i+:4]} + {1'b0, bc[4*i+:4]} + {4'h0, cy};
                cy = t >= 5'd10;
                r[4*i+:4] = cy ? 4'(t - 5'd10) : t[3:0];
            end
        end else begin
            // subtract the smaller magnitude, no recomplement pass needed
            x  = (ba >= bc) ? ba : bc;
            y  = (ba >= bc) ? bc : ba;
            sg = (ba >= bc) ? a[SIGN_BIT] : c[SIGN_BIT];
            for (int i = 0; i < DIGITS; i++) begin
                t  = {1'b0, x[4*i+:4]} - {1'b0, y[4*i+:4]} - {4'h0, cy};
                cy = t[4];
                r[4*i+:4] = cy ? 4'(t + 5'd10) : t[3:0];
            end
        end
        if (r == '0) begin
            sg = 1'b0;
        end
        for (int i = 0; i < DIGITS; i++) begin
            r[4*i+:4] = r[4*i+:4] + XS3_ZERO;
        end
        xs3_add = {sg, r};
    endfunction

    // execute-stage operand shaping
    wire [MAG_W-1:0]  mem_mag  = mem_rdata_i[MAG_W-1:0];
    wire              mem_sgn  = mem_rdata_i[SIGN_BIT];
    wire [1:0]        prim_idx = low_idx(bank_r);
    wire [WORD_W-1:0] sec_op   = field_control_word_r ? {1'b0, mem_mag & mask_r} : mem_rdata_i;
    wire [WORD_W-1:0] sum_w    = xs3_add(ar_r[prim_idx], sec_op);
    wire              sum_zero = sum_w == {1'b0, {DIGITS{XS3_ZERO}}};
    wire              do_exec  = st_r == ST_EXEC;

    // apb decode
    wire       apb_acc  = psel && penable;
    wire       hit_ar   = paddr[7:4] == OFF_AR_BASE[7:4] && paddr[1:0] == 2'b00;
    wire       hit_ctrl = paddr == OFF_CTRL;
    wire       hit_stat = paddr == OFF_STAT;
    wire       hit_xr   = paddr[7:6] == OFF_XR_BASE[7:6] && paddr[1:0] == 2'b00;
    wire       apb_hit  = hit_ar || hit_ctrl || hit_stat || hit_xr;
    wire       apb_wr   = apb_acc && pwrite;
    wire [1:0] ar_sel   = paddr[3:2];
    wire [3:0] xr_sel   = paddr[5:2];
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ar) begin
            rd_mux = {7'h00, ar_r[ar_sel]};
        end else if (hit_xr) begin
            rd_mux = {17'h0_0000, xr_r[xr_sel]};
        end else if (hit_ctrl) begin
            rd_mux[CTRL_EN_BIT] = en_r;
        end else if (hit_stat) begin
            rd_mux[STAT_ZERO_BIT]  = zero_flag_r;
            rd_mux[STAT_BUSY_BIT]  = st_r != ST_IDLE;
            rd_mux[STAT_CWERR_BIT] = cwerr_r;
        end
    end
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !apb_hit;
    assign prdata  = prdata_r;

    // state sequencing
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (accept && op_ours) begin
                    st_nxt = instr_i.ia ? ST_CTRL : op_is_st ? ST_STCLR : ST_OPRD;
                end
            end
            ST_CTRL:  st_nxt = ST_CWAN;
            ST_CWAN:  st_nxt = cw_bad ? ST_IDLE : cur_store ? ST_STCLR : ST_EXEC;
            ST_OPRD:  st_nxt = ST_EXEC;
            ST_EXEC:  st_nxt = ST_IDLE;
            ST_STCLR: st_nxt = ST_STWR;
            ST_STWR:  st_nxt = (pend_r & (pend_r - 4'h1)) != 4'h0 ? ST_STCLR : ST_IDLE;
            default:  st_nxt = ST_IDLE;
        endcase
    end

    assign instr_ready_o      = st_r == ST_IDLE && en_r;
    assign done_o             = (do_exec || (st_r == ST_STWR && st_nxt == ST_IDLE)
                                 || (st_r == ST_CWAN && cw_bad));
    assign zero_result_flag_o = zero_flag_r;

    // memory request; foreign opcodes never leave idle so nothing is driven
    wire [1:0] st_idx = low_idx(pend_r);
    wire [WORD_W-1:0] st_word = {ar_r[st_idx][SIGN_BIT] ^ (op_r == OP_STORE_NEG),
                                 ar_r[st_idx][MAG_W-1:0]};
    assign mem_req_o.rd    = st_r == ST_CTRL || st_r == ST_OPRD
                             || (st_r == ST_CWAN && !cur_store && !cw_bad);
    // an empty bank names no register, so a store must not touch memory
    assign mem_req_o.wr    = (st_r == ST_STCLR || st_r == ST_STWR) && pend_r != 4'h0;
    assign mem_req_o.addr  = (st_r == ST_CWAN) ? cw_addr : addr_r;
    // target is zeroed one cycle before the data lands
    assign mem_req_o.wdata = (st_r == ST_STWR) ? st_word : '0;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r    <= ST_IDLE;
            op_r    <= 6'h00;
            bank_r  <= 4'h0;
            pend_r  <= 4'h0;
            addr_r  <= '0;
        end else begin
            st_r <= st_nxt;
            if (accept && op_ours) begin
                op_r   <= instr_i.op;
                bank_r <= instr_i.bank;
                pend_r <= instr_i.bank;
                addr_r <= m_idx;
            end else if (st_r == ST_CWAN) begin
                addr_r <= cw_addr;
            end else if (st_r == ST_STWR) begin
                // more significant words sit at lower addresses
                pend_r <= pend_r & (pend_r - 4'h1);
                addr_r <= addr_r - 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            field_control_word_r <= 1'b0;
            mask_r <= '1;
        end else if (accept) begin
            field_control_word_r <= 1'b0;
            mask_r <= '1;
        end else if (st_r == ST_CWAN && cw_field_control_word) begin
            field_control_word_r <= !cur_store;
            mask_r <= cw_mask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            en_r        <= CTRL_EN_RST;
            cwerr_r     <= 1'b0;
            zero_flag_r <= 1'b0;
            prdata_r    <= 32'h0000_0000;
        end else begin
            if (apb_wr && hit_ctrl) begin
                en_r <= pwdata[CTRL_EN_BIT];
            end
            // a new fault wins over a same-cycle clear
            if (st_r == ST_CWAN && cw_bad) begin
                cwerr_r <= 1'b1;
            end else if (apb_wr && hit_stat && pwdata[STAT_CWERR_BIT]) begin
                cwerr_r <= 1'b0;
            end
            if (do_exec && op_r == OP_DEC_ADD && bank_r != 4'h0) begin
                zero_flag_r <= sum_zero;
            end
            if (psel && !penable) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // index registers; entry 0 means no modification
    genvar k;
    generate
        for (k = 0; k < NUM_XR; k++) begin : g_xr
            always_ff @(posedge clk_i) begin
                if (sys_rst_i || k == 0) begin
                    xr_r[k] <= '0;
                end else if (apb_wr && hit_xr && xr_sel == 4'(k)) begin
                    xr_r[k] <= pwdata[ADDR_W-1:0];
                end
            end
        end
        for (k = 0; k < NUM_AR; k++) begin : g_ar
            logic [WORD_W-1:0] ld_val;
            logic              exec_wr;
            // field load starts from the old register, plain loads from zero
            wire [MAG_W-1:0] base = (op_r == OP_LOAD_FIELD) ? ar_r[k][MAG_W-1:0]
                                                             : '0;
            wire [MAG_W-1:0] mrg  = (base & ~mask_r) | (mem_mag & mask_r);
            always_comb begin
                ld_val  = ar_r[k];
                exec_wr = 1'b0;
                case (op_r)
                    OP_LOAD: begin
                        exec_wr = bank_r[k];
                        ld_val  = {mem_sgn && !field_control_word_r, mrg};
                    end
                    OP_LOAD_NEG: begin
                        exec_wr = bank_r[k];
                        ld_val  = {field_control_word_r || !mem_sgn, mrg};
                    end
                    OP_LOAD_FIELD: begin
                        exec_wr = bank_r[k];
                        ld_val  = {ar_r[k][SIGN_BIT], mrg};
                    end
                    OP_DEC_ADD: begin
                        // single destination: the lowest named register
                        exec_wr = bank_r[k] && prim_idx == 2'(k);
                        ld_val  = sum_w;
                    end
                    default: begin
                        exec_wr = 1'b0;
                        ld_val  = ar_r[k];
                    end
                endcase
            end
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    ar_r[k] <= '0;
                end else if (do_exec && exec_wr) begin
                    ar_r[k] <= ld_val;
                end else if (apb_wr && hit_ar && ar_sel == 2'(k)) begin
                    ar_r[k] <= pwdata[WORD_W-1:0];
                end
            end
        end
    endgenerate

    // checks
    sequence s_load_path;
        st_r == ST_OPRD ##1 st_r == ST_EXEC ##1 st_r == ST_IDLE;
    endsequence
    sequence s_cw_path;
        st_r == ST_CTRL ##1 st_r == ST_CWAN ##1 (st_r == ST_EXEC || $past(cw_bad));
    endsequence

    property p_load_two;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && instr_i.op == OP_LOAD && !instr_i.ia |=> s_load_path;
    endproperty
    a_load_two: assert property (p_load_two) else $error("load not two cycles");

    property p_neg_sign;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_exec && op_r == OP_LOAD_NEG && !field_control_word_r && bank_r[3]
        |=> ar_r[3][SIGN_BIT] == !$past(mem_sgn);
    endproperty
    a_neg_sign: assert property (p_neg_sign) else $error("negated load sign wrong");

    property p_neg_field;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_exec && op_r == OP_LOAD_NEG && field_control_word_r && bank_r[1] |=> ar_r[1][SIGN_BIT];
    endproperty
    a_neg_field: assert property (p_neg_field) else $error("field negated not neg");

    property p_field_keep;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_exec && op_r == OP_LOAD_FIELD && bank_r[0]
        |=> ar_r[0][SIGN_BIT] == $past(ar_r[0][SIGN_BIT])
            && (ar_r[0][MAG_W-1:0] & ~$past(mask_r))
               == ($past(ar_r[0][MAG_W-1:0]) & ~$past(mask_r));
    endproperty
    a_field_keep: assert property (p_field_keep) else $error("field load disturbed");

    property p_field_three;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && instr_i.op == OP_LOAD_FIELD && instr_i.ia |=> s_cw_path;
    endproperty
    a_field_three: assert property (p_field_three) else $error("field load timing");

    property p_store_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && op_is_st && !instr_i.ia && instr_i.bank != 4'h0
        |=> mem_req_o.wr && mem_req_o.wdata == '0 && mem_req_o.addr == $past(m_idx)
            ##1 mem_req_o.wr && st_r == ST_STWR;
    endproperty
    a_store_clear: assert property (p_store_clear) else $error("store not cleared");

    property p_store_neg;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r == ST_STWR && op_r == OP_STORE_NEG
        |-> mem_req_o.wdata[SIGN_BIT] != ar_r[st_idx][SIGN_BIT];
    endproperty
    a_store_neg: assert property (p_store_neg) else $error("negated store sign");

    property p_zero_flag;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_exec && op_r == OP_DEC_ADD && bank_r != 4'h0
        |=> zero_result_flag_o == (ar_r[$past(prim_idx)][MAG_W-1:0]
                                   == {DIGITS{XS3_ZERO}});
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag mismatch");

    property p_cw_bad;
        @(posedge clk_i) disable iff (sys_rst_i)
        st_r == ST_CWAN && cw_bad |-> !mem_req_o.rd ##1 st_r == ST_IDLE && cwerr_r;
    endproperty
    a_cw_bad: assert property (p_cw_bad) else $error("bad control word ran");

    property p_foreign;
        @(posedge clk_i) disable iff (sys_rst_i)
        accept && !op_ours |=> st_r == ST_IDLE && !mem_req_o.wr && !mem_req_o.rd;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign opcode acted");
endmodule

// >>> otd_mem_model.sv
// synchronous main memory model facing the datapath
`timescale 1ns/1ps
module otd_mem_model
    import otd_pkg::*;
(
    input  wire logic         clk_i,
    input  wire otd_mem_req_s mem_req_i,
    output logic [24:0]       mem_rdata_o
);
    logic [24:0] mem [0:1023];
    initial mem_rdata_o = 25'h0;
    always @(posedge clk_i) begin
        if (mem_req_i.wr) begin
            mem[mem_req_i.addr[9:0]] <= mem_req_i.wdata;
        end
        // idle cycles flip the data, so a stale word reads back inverted after an odd number of them and unchanged after an even number
        mem_rdata_o <= mem_req_i.rd ? mem[mem_req_i.addr[9:0]] : ~mem_rdata_o;
    end
endmodule

// >>> tb_top.sv
// self-checking bench for the operand transfer datapath
`timescale 1ns/1ps
module tb_top;
    import otd_pkg::*;
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    otd_instr_s   instr = '0;
    logic         ivalid = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         iready, done, zflag, pready, pslverr;
    otd_mem_req_s mreq;
    logic [24:0]  mrd, va, vb;
    logic [24:0]  a [4];
    logic [32:0]  rq [$];
    logic [32:0]  exp_rd;
    logic [39:0]  wq [$];
    int           dq [$];
    int           failures = 0;
    int           check_count = 0;
    int           lat = 0;
    int           seed = 32'hdbad;
    always #5 clk_i = ~clk_i;
    otd_datapath otd_datapath_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr),
        .instr_valid_i(ivalid), .instr_ready_o(iready), .done_o(done), .mem_req_o(mreq),
        .mem_rdata_i(mrd), .zero_result_flag_o(zflag), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    otd_mem_model otd_mem_model_inst (.clk_i(clk_i), .mem_req_i(mreq), .mem_rdata_o(mrd));
    task automatic final_report();
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // k=1 waits for instruction ready, k=0 for apb ready
    task automatic waitfor(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((k ? iready : pready) !== 1'b1 && n < 64);
        if (n >= 64) begin
            failures++;
            final_report();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        waitfor(0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic run(input otd_instr_s i, input int l);
        if (l > 0) begin
            dq.push_back(l);
        end
        instr <= i;
        ivalid <= 1'b1;
        waitfor(1);
        ivalid <= 1'b0;
        waitfor(1);
    endtask
    task automatic pm(input int ad, input logic [24:0] v);
        otd_mem_model_inst.mem[ad] = v;
    endtask
    always @(posedge clk_i) begin
        if (!sys_rst_i) begin
            lat = (ivalid && iready) ? 0 : lat + 1;
            if (psel && penable && pready && !pwrite) begin
                exp_rd = rq.pop_front();
                chk({7'h0, pslverr, prdata}, {7'h0, exp_rd});
                if (paddr == OFF_STAT) begin
                    chk(40'(zflag), 40'(exp_rd[STAT_ZERO_BIT]));
                end
            end
            if (mreq.wr) begin
                chk({mreq.addr, mreq.wdata}, wq.pop_front());
            end
            if (done) begin
                chk(40'(lat), 40'(dq.pop_front()));
            end
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            a[i] = 25'($random(seed));
        end
        va = 25'($random(seed));
        vb = 25'($random(seed));
        pm(100, va);
        pm(400, {1'b0, 4'h0, 5'h0f, 5'h04, 10'd401});
        pm(401, vb);
        pm(402, vb);
        pm(500, 25'h0333335);
        pm(501, 25'h0000005);
        pm(502, {1'b1, 24'h333338});
        pm(410, {1'b1, 4'h0, 5'h0f, 5'h04, 10'd401});
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFF_CTRL, 33'h1);
        rd(OFF_STAT, 33'h0);
        apb(1'b1, 8'h20, 32'h1);
        rd(8'h20, {1'b1, 32'h0});
        apb(1'b1, OFF_XR_BASE + 8'h0c, 32'h5);
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i), 33'h0);
            apb(1'b1, 8'(4 * i), 32'(a[i]));
            rd(8'(4 * i), 33'(a[i]));
        end
        run('{1'b0, 4'h0, OP_LOAD, 4'h6, 10'd100}, 2);
        rd(8'h00, 33'(a[0]));
        rd(8'h04, 33'(va));
        rd(8'h08, 33'(va));
        rd(8'h0c, 33'(a[3]));
        run('{1'b0, 4'h3, OP_LOAD_NEG, 4'h8, 10'd95}, 2);
        rd(8'h0c, {8'h0, ~va[24], va[23:0]});
        wq = '{{15'd200, 25'h0}, {15'd200, a[0]}, {15'd199, 25'h0}, {15'd199, va}};
        run('{1'b0, 4'h0, OP_STORE, 4'h3, 10'd200}, 4);
        wq = '{{15'd300, 25'h0}, {15'd300, ~va[24], va[23:0]}};
        run('{1'b0, 4'h0, OP_STORE_NEG, 4'h4, 10'd300}, 2);
        rd(8'h08, 33'(va));
        run('{1'b1, 4'h0, OP_LOAD_FIELD, 4'h1, 10'd400}, 3);
        rd(8'h00, {8'h0, a[0][24:12], vb[11:0]});
        run('{1'b0, 4'h0, OP_LOAD_FIELD, 4'h2, 10'd402}, 2);
        rd(8'h04, {8'h0, va[24], vb[23:0]});
        apb(1'b1, 8'h00, 32'h0333334);
        run('{1'b0, 4'h0, OP_DEC_ADD, 4'h1, 10'd500}, 2);
        rd(8'h00, 33'h0333336);
        run('{1'b0, 4'h0, OP_DEC_ADD, 4'h1, 10'd501}, 2);
        rd(8'h00, 33'h0333338);
        rd(OFF_STAT, 33'h0);
        run('{1'b0, 4'h0, OP_DEC_ADD, 4'h1, 10'd502}, 2);
        rd(8'h00, 33'h0333333);
        rd(OFF_STAT, 33'h1);
        run('{1'b0, 4'h0, 6'h3f, 4'hf, 10'd100}, 0);
        rd(8'h00, 33'h0333333);
        rd(8'h04, {8'h0, va[24], vb[23:0]});
        // field-selected negated load ends negative, unselected bits cleared
        run('{1'b1, 4'h0, OP_LOAD_NEG, 4'h2, 10'd400}, 3);
        rd(8'h04, {8'h0, 1'b1, 12'h000, vb[11:0]});
        // control word with its indirect bit set is refused
        run('{1'b1, 4'h0, OP_LOAD_FIELD, 4'h1, 10'd410}, 2);
        rd(8'h00, 33'h0333333);
        rd(OFF_STAT, 33'h5);
        apb(1'b1, OFF_STAT, 32'h4);
        rd(OFF_STAT, 33'h1);
        repeat (4) @(posedge clk_i);
        // every noted result must have been seen
        chk(40'(rq.size() + wq.size() + dq.size()), 40'h0);
        final_report();
    end
endmodule
